// ---- hdl/pmpm_top.sv ----
/*
  program memory partition map: program counter with vectors, region
  decode from latched configuration, indirect pointer routing to
  program or data memory, write protection and execution checking.
  assumes flash and data memory answer one cycle after a read enable,
  and configuration inputs are stable, same-clock logic.
*/
`timescale 1ns/1ps
`include "pmpm_cfg.svh"

// Summary of operation
// [R1] fifteen bit counter spans 32K fourteen-bit words
// [R2] reset fetches 0000h, interrupt fetches 0004h
// [R3] flash end 1FFFh, 3FFFh or 7FFFh
// [R4] pointer high bit 7 selects program memory
// [R5] program reads return low eight bits
// [R6] indirect writes never alter program memory
// [R7] program reads through pointer take one more cycle
// [R8] both enables high: whole flash is application
// [R9] boot enable low: boot region from zero
// [R10] storage enable low: 128 words at top
// [R11] storage starts last minus 7Fh; app ends minus 80h
// [R12] storage region is not executable
// [R13] each region has its own write protect
// [R14] protected write: no change, error flag set
// [R15] bad fetch: violation reset, violation flag cleared
// [R16] partition decoded from configuration latched at reset
module pmpm_top #(
  parameter int DATA_W = 14,
  parameter int BUS_W  = 16
) (
  input  wire logic               clk,
  input  wire logic               rst_b,
  // configuration words
  input  wire logic [1:0]         flash_size_sel,
  input  wire logic               boot_region_enable_n,
  input  wire logic               storage_region_enable_n,
  input  wire logic [2:0]         boot_region_size_sel,
  input  wire logic               app_region_write_protect,
  input  wire logic               boot_region_write_protect,
  input  wire logic               storage_region_write_protect,
  // fetch side
  input  wire logic               pc_inc,
  input  wire logic               pc_load,
  input  wire logic [14:0]        pc_load_addr,
  input  wire logic               irq_enter,
  input  wire logic               fetch_valid,
  output logic      [14:0]        fetch_addr,
  output logic                    exec_violation_reset,
  // indirect access port
  input  wire logic               ind_req,
  input  wire logic               ind_wr,
  input  wire logic [7:0]         pointer_high_byte,
  input  wire logic [7:0]         pointer_low_byte,
  input  wire logic [7:0]         ind_wdata,
  output logic                    ind_done,
  output logic      [7:0]         ind_rdata,
  // program flash read port
  output logic                    pm_rd_en,
  output logic      [14:0]        pm_rd_addr,
  input  wire logic [DATA_W-1:0]  pm_rd_data,
  // data memory port
  output logic                    dm_rd_en,
  output logic                    dm_wr_en,
  output logic      [14:0]        dm_addr,
  output logic      [7:0]         dm_wdata,
  input  wire logic [7:0]         dm_rd_data,
  // nvm control write check
  input  wire logic               nvm_wr_req,
  input  wire logic [14:0]        nvm_wr_addr,
  output logic                    nvm_wr_grant,
  output logic                    nvm_write_error_flag,
  // register port
  input  wire logic [7:0]         reg_addr,
  input  wire logic [BUS_W-1:0]   reg_wdata,
  input  wire logic               reg_wr,
  input  wire logic               reg_rd,
  output logic      [BUS_W-1:0]   reg_rdata,
  output logic                    irq
);

  // ----------------------------------------------------------------
  // reset synchroniser
  // ----------------------------------------------------------------
  logic rst_meta_reg;
  logic rst_n;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_reg <= 1'b0;
      rst_n        <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n        <= rst_meta_reg;
    end
  end

  // ----------------------------------------------------------------
  // configuration latch
  // ----------------------------------------------------------------
  // captured once after release so a change of the configuration inputs
  // later never moves a boundary under running code
  logic        cfg_done_reg;
  logic [1:0]  size_sel_reg;
  logic        boot_en_n_reg;
  logic        store_en_n_reg;
  logic [2:0]  boot_sel_reg;
  logic [2:0]  wp_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_done_reg  <= 1'b0;
      size_sel_reg  <= 2'h2;
      boot_en_n_reg <= 1'b1;
      store_en_n_reg <= 1'b1;
      boot_sel_reg  <= 3'h0;
      wp_reg        <= 3'h0;
    end else if (!cfg_done_reg) begin                          // [R16]
      cfg_done_reg  <= 1'b1;
      size_sel_reg  <= flash_size_sel;
      boot_en_n_reg <= boot_region_enable_n;
      store_en_n_reg <= storage_region_enable_n;
      boot_sel_reg  <= boot_region_size_sel;
      wp_reg        <= {storage_region_write_protect,
                        boot_region_write_protect,
                        app_region_write_protect};             // [R13]
    end
  end

  // ----------------------------------------------------------------
  // partition boundaries
  // ----------------------------------------------------------------
  logic [14:0] last_addr;
  logic [14:0] store_start;
  logic [14:0] app_end;
  logic [14:0] boot_last;
  logic [14:0] boot_raw;

  assign last_addr = (size_sel_reg == 2'h0) ? `PMPM_LAST_8K :
                     (size_sel_reg == 2'h1) ? `PMPM_LAST_16K :
                                              `PMPM_LAST_32K;  // [R3]
  assign store_start = last_addr - `PMPM_STORE_OFS;            // [R11]
  assign app_end   = store_en_n_reg ? last_addr
                     : last_addr - `PMPM_APP_END_OFS;          // [R10]
  // sizes past the application end are clamped to keep one app word
  assign boot_raw  = 15'((`PMPM_BOOT_BASE << boot_sel_reg) - 1);
  assign boot_last = (boot_raw >= app_end) ? app_end - 15'h0001
                     : boot_raw;                               // [R9]

  function automatic pmpm_pkg::pmpm_region_t region_of(
    input logic [14:0] a
  );
    pmpm_pkg::pmpm_region_t r;
    r = pmpm_pkg::PMPM_REG_NONE;
    if (a > last_addr)
      r = pmpm_pkg::PMPM_REG_NONE;
    else if (!store_en_n_reg && a >= store_start)
      r = pmpm_pkg::PMPM_REG_STORE;                            // [R10]
    else if (!boot_en_n_reg && a <= boot_last)
      r = pmpm_pkg::PMPM_REG_BOOT;                             // [R9]
    else
      r = pmpm_pkg::PMPM_REG_APP;                              // [R8]
    return r;
  endfunction

  // ----------------------------------------------------------------
  // program counter and execution check
  // ----------------------------------------------------------------
  logic [`PMPM_PC_W-1:0] pc_reg;                               // [R1]
  logic                  viol_reg;
  logic                  vflag_reg;
  logic                  fetch_bad;
  pmpm_pkg::pmpm_region_t fetch_region;

  // a process, not an assign: the function reads the latched boundaries
  always_comb fetch_region = region_of(pc_reg);
  assign fetch_bad = fetch_valid &&
    (fetch_region == pmpm_pkg::PMPM_REG_NONE ||
     fetch_region == pmpm_pkg::PMPM_REG_STORE);                // [R12]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      pc_reg <= `PMPM_RESET_VEC;                               // [R2]
    else if (fetch_bad)
      pc_reg <= `PMPM_RESET_VEC;                               // [R15]
    else if (irq_enter)
      pc_reg <= `PMPM_IRQ_VEC;                                 // [R2]
    else if (pc_load)
      pc_reg <= pc_load_addr;
    else if (pc_inc)
      pc_reg <= pc_reg + 15'h0001;
  end

  assign fetch_addr = pc_reg;

  // ----------------------------------------------------------------
  // control register write decode
  // ----------------------------------------------------------------
  logic wr_mask;
  logic wr_ctrl;
  logic rd_stat;

  assign wr_mask = reg_wr && reg_addr == `PMPM_OFS_IRQ_MASK;
  assign wr_ctrl = reg_wr && reg_addr == `PMPM_OFS_CTRL;
  assign rd_stat = reg_rd && reg_addr == `PMPM_OFS_IRQ_STAT;

  // violation flag is cleared by hardware, set by writing 1
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      viol_reg  <= 1'b0;
      vflag_reg <= `PMPM_VFLAG_RST;
    end else begin
      viol_reg <= fetch_bad;                                   // [R15]
      if (fetch_bad)
        vflag_reg <= 1'b0;                                     // [R15]
      else if (wr_ctrl && reg_wdata[0])
        vflag_reg <= 1'b1;
    end
  end

  assign exec_violation_reset = viol_reg;

  // ----------------------------------------------------------------
  // indirect access routing
  // ----------------------------------------------------------------
  pmpm_pkg::pmpm_ind_state_t ind_st_reg;
  pmpm_pkg::pmpm_ind_state_t ind_st_next;
  logic       ind_pm;
  logic       ind_idle;
  logic       pm_wr_drop;
  logic       dm_rd_pend_reg;
  logic       done_reg;
  logic [7:0] rdata_reg;

  assign ind_idle   = ind_st_reg == pmpm_pkg::PMPM_IND_IDLE;
  assign ind_pm     = pointer_high_byte[`PMPM_PTR_PM_BIT];     // [R4]
  assign pm_wr_drop = ind_idle && ind_req && ind_wr && ind_pm; // [R6]

  assign pm_rd_en   = ind_idle && ind_req && !ind_wr && ind_pm;
  assign pm_rd_addr = {pointer_high_byte[6:0], pointer_low_byte};
  assign dm_rd_en   = ind_idle && ind_req && !ind_wr && !ind_pm;
  assign dm_wr_en   = ind_idle && ind_req && ind_wr && !ind_pm;
  assign dm_addr    = {pointer_high_byte[6:0], pointer_low_byte};
  assign dm_wdata   = ind_wdata;

  always_comb begin
    ind_st_next = ind_st_reg;
    case (ind_st_reg)
      pmpm_pkg::PMPM_IND_IDLE:
        if (pm_rd_en)
          ind_st_next = pmpm_pkg::PMPM_IND_PM_WAIT;            // [R7]
      pmpm_pkg::PMPM_IND_PM_WAIT:
        ind_st_next = pmpm_pkg::PMPM_IND_PM_DONE;
      pmpm_pkg::PMPM_IND_PM_DONE:
        ind_st_next = pmpm_pkg::PMPM_IND_IDLE;
      default:
        ind_st_next = pmpm_pkg::PMPM_IND_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ind_st_reg     <= pmpm_pkg::PMPM_IND_IDLE;
      dm_rd_pend_reg <= 1'b0;
      done_reg       <= 1'b0;
      rdata_reg      <= 8'h00;
    end else begin
      ind_st_reg     <= ind_st_next;
      dm_rd_pend_reg <= dm_rd_en;
      done_reg       <= dm_rd_en || dm_wr_en || pm_wr_drop ||
        ind_st_reg == pmpm_pkg::PMPM_IND_PM_WAIT;              // [R7]
      if (ind_st_reg == pmpm_pkg::PMPM_IND_PM_WAIT)
        rdata_reg <= pm_rd_data[7:0];                          // [R5]
      else if (dm_rd_pend_reg)
        rdata_reg <= dm_rd_data;
    end
  end

  // a data read is done in the cycle memory answers; its byte shows on
  // ind_rdata one cycle later, from the register
  assign ind_done  = ind_st_reg == pmpm_pkg::PMPM_IND_PM_DONE ||
                     (done_reg && !dm_rd_pend_reg) || dm_rd_pend_reg;
  assign ind_rdata = rdata_reg;

  // ----------------------------------------------------------------
  // nvm write protection
  // ----------------------------------------------------------------
  pmpm_pkg::pmpm_region_t nvm_region;
  logic nvm_prot;
  logic grant_reg;
  logic wr_err_reg;

  always_comb nvm_region = region_of(nvm_wr_addr);
  assign nvm_prot =
    nvm_region == pmpm_pkg::PMPM_REG_NONE ||
    (nvm_region == pmpm_pkg::PMPM_REG_APP  && wp_reg[0]) ||
    (nvm_region == pmpm_pkg::PMPM_REG_BOOT && wp_reg[1]) ||
    (nvm_region == pmpm_pkg::PMPM_REG_STORE && wp_reg[2]);    // [R13]

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      grant_reg  <= 1'b0;
      wr_err_reg <= 1'b0;
    end else begin
      grant_reg <= nvm_wr_req && !nvm_prot;                    // [R14]
      if (nvm_wr_req && nvm_prot)
        wr_err_reg <= 1'b1;                                    // [R14]
      else if (wr_ctrl && reg_wdata[1])
        wr_err_reg <= 1'b0;
    end
  end

  assign nvm_wr_grant         = grant_reg;
  assign nvm_write_error_flag = wr_err_reg;

  // ----------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------
  logic [`PMPM_EV_N-1:0] ev;
  logic [`PMPM_EV_N-1:0] stat_reg;
  logic [`PMPM_EV_N-1:0] stat_next;
  logic [`PMPM_EV_N-1:0] mask_reg;

  assign ev[`PMPM_EV_WR_ERR]     = nvm_wr_req && nvm_prot;
  assign ev[`PMPM_EV_EXEC_VIOL]  = fetch_bad;
  assign ev[`PMPM_EV_PM_WR_DROP] = pm_wr_drop;
  // a set in the cycle of the clearing read survives it
  assign stat_next = (rd_stat ? '0 : stat_reg) | ev;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      stat_reg <= '0;
      mask_reg <= `PMPM_MASK_RST;
    end else begin
      stat_reg <= stat_next;
      if (wr_mask)
        mask_reg <= reg_wdata[`PMPM_EV_N-1:0];
    end
  end

  assign irq = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // register read
  // ----------------------------------------------------------------
  logic [BUS_W-1:0] rd_mux;
  logic [BUS_W-1:0] rdata_q;

  assign rd_mux =
    (reg_addr == `PMPM_OFS_IRQ_STAT) ? BUS_W'(stat_reg) :
    (reg_addr == `PMPM_OFS_IRQ_MASK) ? BUS_W'(mask_reg) :
    (reg_addr == `PMPM_OFS_CTRL) ? BUS_W'({wr_err_reg, vflag_reg}) :
    (reg_addr == `PMPM_OFS_PART) ?
      BUS_W'({wp_reg, boot_sel_reg, store_en_n_reg, boot_en_n_reg,
              size_sel_reg, cfg_done_reg}) :
    (reg_addr == `PMPM_OFS_LAST) ? BUS_W'(last_addr) :
    (reg_addr == `PMPM_OFS_BOOT_LAST) ? BUS_W'(boot_last) :
    '0;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      rdata_q <= '0;
    else
      rdata_q <= reg_rd ? rd_mux : '0;
  end

  assign reg_rdata = rdata_q;

endmodule

// ---- hdl/pmpm_cfg.svh ----
/*
  constants of the program memory partition map: vectors, region
  sizes, register offsets and reset values.
  assumes it is included by its bare name, once or more.
*/
`ifndef PMPM_CFG_SVH
`define PMPM_CFG_SVH

// ----------------------------------------------------------------
// address space
// ----------------------------------------------------------------
`define PMPM_PC_W          15
`define PMPM_RESET_VEC     15'h0000
`define PMPM_IRQ_VEC       15'h0004
`define PMPM_LAST_8K       15'h1fff
`define PMPM_LAST_16K      15'h3fff
`define PMPM_LAST_32K      15'h7fff
`define PMPM_STORE_OFS     15'h007f
`define PMPM_APP_END_OFS   15'h0080
`define PMPM_BOOT_BASE     15'h0200
`define PMPM_PTR_PM_BIT    7

// ----------------------------------------------------------------
// register map (byte offsets)
// ----------------------------------------------------------------
`define PMPM_OFS_IRQ_STAT  8'h00
`define PMPM_OFS_IRQ_MASK  8'h04
`define PMPM_OFS_CTRL      8'h08
`define PMPM_OFS_PART      8'h0c
`define PMPM_OFS_LAST      8'h10
`define PMPM_OFS_BOOT_LAST 8'h14

// ----------------------------------------------------------------
// fields and reset values
// ----------------------------------------------------------------
`define PMPM_EV_WR_ERR     0
`define PMPM_EV_EXEC_VIOL  1
`define PMPM_EV_PM_WR_DROP 2
`define PMPM_EV_N          3
`define PMPM_MASK_RST      3'h0
`define PMPM_VFLAG_RST     1'b1

`endif

// ---- hdl/pmpm_pkg.sv ----
/*
  types of the program memory partition map.
  assumes nothing beyond a SystemVerilog compiler.
*/
package pmpm_pkg;

  typedef enum logic [1:0] {
    PMPM_REG_APP,
    PMPM_REG_BOOT,
    PMPM_REG_STORE,
    PMPM_REG_NONE
  } pmpm_region_t;

  typedef enum logic [1:0] {
    PMPM_IND_IDLE,
    PMPM_IND_PM_WAIT,
    PMPM_IND_PM_DONE
  } pmpm_ind_state_t;

endpackage

// ---- tb/pmpm_mem_model.sv ----
/*
  behavioural flash and data memory beside the partition map.
  assumes read enables are one-cycle pulses; data stand one cycle later.
*/
`timescale 1ns/1ps
module pmpm_mem_model (
  input  wire logic        clk,
  input  wire logic        pm_rd_en,
  input  wire logic [14:0] pm_rd_addr,
  output logic      [13:0] pm_rd_data,
  input  wire logic        dm_rd_en,
  input  wire logic [14:0] dm_addr,
  output logic      [7:0]  dm_rd_data
);
  logic        pm_vld_reg;
  logic        dm_vld_reg;
  logic [14:0] pm_adr_reg;
  logic [14:0] dm_adr_reg;
  logic [13:0] pm_word;
  logic [7:0]  dm_byte;

  always_ff @(posedge clk) begin
    pm_vld_reg <= pm_rd_en;
    pm_adr_reg <= pm_rd_addr;
    dm_vld_reg <= dm_rd_en;
    dm_adr_reg <= dm_addr;
  end
  // upper bits nonzero so a missing low-byte select shows
  assign pm_word = {pm_adr_reg[5:0], ~pm_adr_reg[7:0]};
  assign dm_byte = dm_adr_reg[7:0] ^ 8'h5a;
  // outside the answer cycle the lines invert, so stale data never match
  assign pm_rd_data = pm_vld_reg ? pm_word : ~pm_word;
  assign dm_rd_data = dm_vld_reg ? dm_byte : ~dm_byte;
endmodule

// ---- tb/pmpm_properties.sv ----
/*
  port-level assertions of the partition map top.
  assumes one clock and the bind at the foot of this file.
*/
`timescale 1ns/1ps
module pmpm_properties #(
  parameter int DATA_W = 14
) (
  input wire logic              clk,
  input wire logic              rst_b,
  input wire logic              irq_enter,
  input wire logic              fetch_valid,
  input wire logic [14:0]       fetch_addr,
  input wire logic              exec_violation_reset,
  input wire logic              ind_req,
  input wire logic              ind_wr,
  input wire logic [7:0]        pointer_high_byte,
  input wire logic [7:0]        pointer_low_byte,
  input wire logic              ind_done,
  input wire logic [7:0]        ind_rdata,
  input wire logic              pm_rd_en,
  input wire logic [14:0]       pm_rd_addr,
  input wire logic [DATA_W-1:0] pm_rd_data,
  input wire logic              dm_rd_en,
  input wire logic              dm_wr_en,
  input wire logic              nvm_wr_req,
  input wire logic              nvm_wr_grant,
  input wire logic              nvm_write_error_flag,
  input wire logic              reg_wr
);
  wire logic [7:0] pm_low = pm_rd_data[7:0];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  viol_cause_a: assert property (
    exec_violation_reset |-> fetch_addr == 15'h0000 && $past(fetch_valid))
    else $error("violation reset without fetch");
  irq_vector_a: assert property (
    irq_enter && !fetch_valid |=> fetch_addr == 15'h0004)
    else $error("interrupt vector wrong");
  pm_route_a: assert property (
    pm_rd_en |-> pointer_high_byte[7] && !ind_wr && !dm_rd_en &&
    pm_rd_addr == {pointer_high_byte[6:0], pointer_low_byte})
    else $error("program read routed wrong");
  pm_wait_a: assert property (
    pm_rd_en |=> !ind_done ##1 (ind_done && ind_rdata == $past(pm_low)))
    else $error("program read timing or data wrong");
  pm_nowrite_a: assert property (
    ind_req && ind_wr && pointer_high_byte[7] |-> !dm_wr_en && !pm_rd_en)
    else $error("program write reached a port");
  dm_quick_a: assert property (
    dm_wr_en |=> ind_done)
    else $error("data write not done next cycle");
  err_cause_a: assert property (
    $rose(nvm_write_error_flag) |-> $past(nvm_wr_req) && !nvm_wr_grant)
    else $error("write error without refused request");
  err_sticky_a: assert property (
    nvm_write_error_flag && !reg_wr |=> nvm_write_error_flag)
    else $error("write error flag dropped");
  grant_cause_a: assert property (
    nvm_wr_grant |-> $past(nvm_wr_req) && !$rose(nvm_write_error_flag))
    else $error("grant without clean request");
  pm_read_c: cover property (pm_rd_en ##2 ind_done);
  viol_c: cover property (exec_violation_reset);
  grant_c: cover property (nvm_wr_grant);
endmodule

bind pmpm_top pmpm_properties #(.DATA_W(DATA_W)) i_chk (.*);

// ---- tb/tb_top.sv ----
/*
  self-checking bench of the partition map top.
  assumes the memory model answers one cycle after each read enable.
*/
`timescale 1ns/1ps
module tb_top;
  logic        clk, rst_b, pc_inc, pc_load, irq_enter, fetch_valid;
  logic        boot_region_enable_n, storage_region_enable_n;
  logic        app_region_write_protect, boot_region_write_protect;
  logic        storage_region_write_protect, exec_violation_reset, irq;
  logic        ind_req, ind_wr, ind_done, pm_rd_en, dm_rd_en, dm_wr_en;
  logic        nvm_wr_req, nvm_wr_grant, nvm_write_error_flag;
  logic        reg_wr, reg_rd;
  logic [1:0]  flash_size_sel;
  logic [2:0]  boot_region_size_sel;
  logic [4:0]  cfg;
  logic [7:0]  pointer_high_byte, pointer_low_byte, ind_wdata, ind_rdata;
  logic [7:0]  dm_wdata, dm_rd_data, reg_addr;
  logic [13:0] pm_rd_data;
  logic [14:0] pc_load_addr, fetch_addr, pm_rd_addr, dm_addr, nvm_wr_addr;
  logic [15:0] reg_wdata, reg_rdata;
  int          mismatches, checks;

  assign {boot_region_enable_n, storage_region_enable_n,
          storage_region_write_protect, boot_region_write_protect,
          app_region_write_protect} = cfg;
  pmpm_top       i_dut (.*);
  pmpm_mem_model i_mem (.*);

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    #400000;
    mismatches++;
    results();
  end
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic ck(input logic ok, input string m);
    checks++;
    if (ok !== 1'b1) begin
      mismatches++;
      $display("CHECK FAILED %0t %s", $time, m);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // configuration is only taken at reset, so each setup resets
  task automatic boot(input logic [1:0] sz, input logic [2:0] bs,
                      input logic [4:0] c);
    @(posedge clk);
    flash_size_sel       <= sz;
    boot_region_size_sel <= bs;
    cfg                  <= c;
    rst_b                <= 1'b0;
    repeat (10) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e,
                    input string m);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 ck(reg_rdata === e, m);
  endtask
  task automatic nvm(input logic [14:0] a, input logic g, input string m);
    @(posedge clk);
    nvm_wr_req  <= 1'b1;
    nvm_wr_addr <= a;
    @(posedge clk);
    nvm_wr_req <= 1'b0;
    #1 ck(nvm_wr_grant === g && (g || nvm_write_error_flag === 1'b1), m);
  endtask
  task automatic fetch(input logic [14:0] a, input logic v, input string m);
    @(posedge clk);
    pc_load      <= 1'b1;
    pc_load_addr <= a;
    @(posedge clk);
    pc_load     <= 1'b0;
    fetch_valid <= 1'b1;
    @(posedge clk);
    fetch_valid <= 1'b0;
    #1 ck(exec_violation_reset === v && fetch_addr === (v ? 15'h0 : a), m);
  endtask
  task automatic ind(input logic w, input logic [7:0] hi,
                     input logic [7:0] lo);
    logic pm;
    pm = hi[7] & ~w;
    @(posedge clk);
    ind_req           <= 1'b1;
    ind_wr            <= w;
    pointer_high_byte <= hi;
    pointer_low_byte  <= lo;
    ind_wdata         <= ~lo;
    #1 ck(pm_rd_en === pm && dm_wr_en === (w & ~hi[7])
          && dm_rd_en === (~w & ~hi[7]), "route");
    if (pm) ck(pm_rd_addr === {hi[6:0], lo}, "pm addr");
    if (!hi[7]) ck(dm_addr === {hi[6:0], lo}
                   && (!w || dm_wdata === ~lo), "dm port");
    @(posedge clk);
    ind_req <= 1'b0;
    #1 ck(ind_done === ~pm, "done c1");
    @(posedge clk);
    #1;
    if (pm) ck(ind_done === 1'b1 && ind_rdata === ~lo, "pm data");
    else if (~w) ck(ind_rdata === (lo ^ 8'h5a), "dm data");
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  initial begin
    {rst_b, pc_inc, pc_load, irq_enter, fetch_valid, ind_req, ind_wr} = '0;
    {nvm_wr_req, reg_wr, reg_rd, flash_size_sel, boot_region_size_sel} = '0;
    {pc_load_addr, pointer_high_byte, pointer_low_byte, ind_wdata} = '0;
    {nvm_wr_addr, reg_addr, reg_wdata, cfg} = '0;
    boot(2'h1, 3'h1, 5'b00001);
    rd(8'h0c, 16'h0123, "part");
    rd(8'h10, 16'h3fff, "last 16k");
    rd(8'h14, 16'h03ff, "boot last");
    rd(8'h08, 16'h0001, "ctrl reset");
    wr(8'h0c, 16'hffff);
    rd(8'h0c, 16'h0123, "part ro");
    rd(8'h20, 16'h0000, "unmapped");
    ck(fetch_addr === 15'h0000, "reset vector");
    nvm(15'h03ff, 1'b1, "boot end");
    nvm(15'h0400, 1'b0, "app start");
    nvm(15'h3f7f, 1'b0, "app end");
    nvm(15'h3f80, 1'b1, "storage start");
    nvm(15'h4000, 1'b0, "past last");
    ck(irq === 1'b0, "masked irq");
    rd(8'h00, 16'h0001, "stat error");
    rd(8'h00, 16'h0000, "stat cleared");
    @(posedge clk) cfg <= 5'b11111;
    wr(8'h04, 16'h0002);
    fetch(15'h3f7f, 1'b0, "app exec");
    fetch(15'h3f80, 1'b1, "storage exec");
    @(posedge clk);
    #1 ck(irq === 1'b1, "irq level");
    rd(8'h00, 16'h0002, "stat viol");
    rd(8'h08, 16'h0002, "ctrl flags");
    @(posedge clk);
    #1 ck(irq === 1'b0, "irq cleared");
    wr(8'h08, 16'h0003);
    rd(8'h08, 16'h0001, "ctrl written");
    @(posedge clk) irq_enter <= 1'b1;
    @(posedge clk) irq_enter <= 1'b0;
    #1 ck(fetch_addr === 15'h0004, "irq vector");
    @(posedge clk) pc_inc <= 1'b1;
    @(posedge clk) pc_inc <= 1'b0;
    #1 ck(fetch_addr === 15'h0005, "pc step");
    ind(1'b0, 8'h81, 8'h23);
    ind(1'b0, 8'h01, 8'h45);
    ind(1'b1, 8'h01, 8'h67);
    ind(1'b1, 8'h82, 8'h89);
    rd(8'h00, 16'h0004, "pm write dropped");
    boot(2'h2, 3'h0, 5'b11001);
    rd(8'h10, 16'h7fff, "last 32k");
    fetch(15'h7fff, 1'b0, "top exec");
    nvm(15'h0000, 1'b0, "low app");
    nvm(15'h7fff, 1'b0, "top app");
    boot(2'h0, 3'h0, 5'b11000);
    rd(8'h10, 16'h1fff, "last 8k");
    fetch(15'h2000, 1'b1, "past 8k");
    results();
  end
endmodule
